// File: link_enable_alarm_monitor_tb_top.sv
// link_enable_alarm_monitor_tb_top.sv: self-checking bench of the link monitor
module link_enable_alarm_monitor_tb_top
	import lkmon_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, resetn, en, sync_n, sub1, tref, locked, dual, swap, oss, cpa = 1'b0, cpb, glt;
	logic stb, calsel, caldone, go, srn, pwr, cken, isk, ilas, lmfc, summ, calpin, a_b, b_a;
	logic [1:0] spa, spb, osa, osb;
	logic [31:0] fa, fb, pa, pb;
	logic [4:0] clr, mask, flags;
	logic [7:0] txc;
	int n_errors, checked, n;
	// ----------------------------------------
	// clocks and partner
	// ----------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// half-rate channel phases; glt skews channel B for one cycle
	always @(posedge clock)
	begin
		cpa <= ~cpa;
		cpb <= ~cpa ^ glt;
	end
	lkmon_rx_model lkmon_rx_model_i (.clk(clock), .rst_n(resetn), .go(go), .tx_is_k(isk),
		.tx_char(txc), .lmfc_edge(lmfc), .sync_n(sync_n));
	lkmon_top lkmon_top_i (.CLOCK(clock), .RESETN(resetn), .LINK_ENABLE_BIT(en),
		.SYNC_N(sync_n), .SUBCLASS1(sub1), .TIMING_REF(tref), .SERDES_PLL_LOCKED(locked),
		.DUAL_MODE(dual), .INPUT_SWAP(swap), .OSC_SYNC_SEL(oss), .OSC_SELECT_PINS_A(spa),
		.OSC_SELECT_PINS_B(spb), .FREQ_WORD_CHAN_A(fa), .FREQ_WORD_CHAN_B(fb),
		.PHASE_WORD_CHAN_A(pa), .PHASE_WORD_CHAN_B(pb), .CLK_PHASE_CHAN_A(cpa),
		.CLK_PHASE_CHAN_B(cpb), .ALARM_CLEAR_WR(clr), .ALARM_CLEAR_STB(stb),
		.ALARM_MASK(mask), .CAL_PIN_ALARM_SEL(calsel), .CAL_DONE(caldone),
		.SERIAL_RESET_N(srn), .SERIALIZER_PWR_ON(pwr), .SERIAL_CLK_EN(cken), .TX_CHAR(txc),
		.TX_IS_K(isk), .ILAS_ACTIVE(ilas), .LMFC_EDGE(lmfc), .ALARM_FLAG_SET(flags),
		.ALARM_SUMMARY(summ), .CAL_ALARM_PIN(calpin), .CHAN_A_FROM_INPUT_B(a_b),
		.CHAN_B_FROM_INPUT_A(b_a), .OSC_SEL_A(osa), .OSC_SEL_B(osb));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	// sample just past the edge so the design's updates have landed
	task automatic look(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results;
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one-cycle write-one-to-clear strobe
	task automatic clear(input logic [4:0] m);
		@(posedge clock);
		clr <= m;
		stb <= 1'b1;
		@(posedge clock);
		stb <= 1'b0;
		look(2);
	endtask
	// bounded wait: a hang counts as a mismatch and ends the run
	task automatic wait_ilas;
		for (int i = 0; i < 200 && ilas !== 1'b1; i++)
			look(1);
		if (ilas !== 1'b1)
		begin
			n_errors++;
			results();
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		n_errors = 0;
		checked = 0;
		{resetn, en, go, sub1, tref, swap, glt, stb, calsel} <= 9'h000;
		{locked, dual, oss, caldone} <= 4'hF;
		spa <= 2'h1;
		spb <= 2'h2;
		fa <= 32'h0000_1000;
		fb <= 32'h0000_3000;
		pa <= 32'h0000_0040;
		pb <= 32'h0000_0040;
		clr <= 5'h00;
		mask <= 5'h1F;
		look(1);
		chk({srn, pwr, cken, flags}, 8'h00);
		@(posedge clock);
		resetn <= 1'b1;
		look(8);
		chk({srn, pwr, cken}, 3'h0);
		chk(flags[ALM_OSC_UPSET], 1'b0);
		chk({osa, osb}, 4'h6);
		chk({a_b, b_a}, 2'h0);
		@(posedge clock);
		swap <= 1'b1;
		fb <= fa;
		look(2);
		chk({a_b, b_a}, 2'h3);
		@(posedge clock);
		en <= 1'b1;
		go <= 1'b1;
		look(1);
		chk({srn, pwr, cken}, 3'h7);
		look(4);
		chk({isk, txc}, {1'b1, K28_5_CHAR});
		wait_ilas();
		n = 0;
		while (ilas === 1'b1 && n < 100)
		begin
			look(1);
			n++;
		end
		chk(n, 64);
		if (n >= 100)
			results();
		chk(lmfc, 1'b1);
		chk(flags[ALM_LINK_DOWN], 1'b1);
		clear(5'h1F);
		chk(flags, 5'h00);
		@(posedge clock);
		locked <= 1'b0;
		@(posedge clock);
		locked <= 1'b1;
		look(3);
		chk({flags, summ, calpin}, 7'h05);
		@(posedge clock);
		mask <= 5'h1E;
		calsel <= 1'b1;
		look(2);
		chk({summ, calpin}, 2'h3);
		clear(5'h1E);
		chk(flags, 5'h01);
		clear(5'h01);
		chk({flags, summ}, 6'h00);
		@(posedge clock);
		fb <= 32'h0000_3000;
		@(posedge clock);
		fb <= fa;
		look(4);
		chk(flags, 5'h08);
		@(posedge clock);
		glt <= 1'b1;
		@(posedge clock);
		glt <= 1'b0;
		look(4);
		chk(flags[ALM_CLK_UPSET], 1'b1);
		clear(5'h10);
		chk(flags[ALM_CLK_UPSET], 1'b0);
		@(posedge clock);
		sub1 <= 1'b1;
		oss <= 1'b0;
		tref <= 1'b1;
		@(posedge clock);
		tref <= 1'b0;
		repeat (5) @(posedge clock);
		tref <= 1'b1;
		@(posedge clock);
		tref <= 1'b0;
		look(3);
		chk(flags[ALM_REALIGN], 1'b1);
		clear(5'h08);
		chk(flags[ALM_OSC_UPSET], 1'b0);
		@(posedge clock);
		en <= 1'b0;
		look(1);
		chk({srn, pwr, cken}, 3'h0);
		@(posedge clock);
		dual <= 1'b0;
		look(2);
		chk({a_b, b_a}, 2'h0);
		results();
	end
endmodule

// File: lkmon_pkg.sv
// lkmon_pkg.sv: constants and types of the link enable and alarm monitor
package lkmon_pkg;
	localparam int LKMON_NUM_ALARMS = 5;
	// alarm flag positions
	localparam int ALM_PLL_UNLOCK = 0;
	localparam int ALM_LINK_DOWN = 1;
	localparam int ALM_REALIGN = 2;
	localparam int ALM_OSC_UPSET = 3;
	localparam int ALM_CLK_UPSET = 4;
	localparam logic [4:0] ALARM_FLAGS_RESET = 5'h00;
	localparam logic [4:0] ALARM_MASK_RESET = 5'h1F;
	// local multiframe clock period minus one, in device clock cycles
	localparam logic [4:0] LMFC_PERIOD_M1 = 5'h0F;
	// alignment sequence length in multiframes
	localparam logic [2:0] ILAS_MULTIFRAMES = 3'h4;
	localparam int OSC_ACC_W = 32;
	localparam logic [7:0] K28_5_CHAR = 8'hBC;
	// oscillator sync trigger choices
	localparam logic OSC_SYNC_BY_REF = 1'b0;
	localparam logic OSC_SYNC_BY_ILAS = 1'b1;
	typedef enum {LK_OFF, LK_CGS, LK_WAIT_LMFC, LK_ILAS, LK_DATA} lkmon_state_e;
endpackage

// File: lkmon_rx_model.sv
// lkmon_rx_model.sv: receiving logic model that drives the sync request
module lkmon_rx_model
	import lkmon_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link side
	input wire logic go,
	input wire logic tx_is_k,
	input wire logic [7:0] tx_char,
	input wire logic lmfc_edge,
	output logic sync_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] k_cnt_ff;
	// request while go; release on a multiframe edge only after four commas
	always_ff @(posedge clk)
	begin
		if (!rst_n || !go)
		begin
			k_cnt_ff <= 3'h0;
			sync_n <= 1'b1;
		end
		else if (k_cnt_ff < 3'h4)
		begin
			sync_n <= 1'b0;
			if (tx_is_k && tx_char == K28_5_CHAR)
				k_cnt_ff <= k_cnt_ff + 3'h1;
		end
		else if (lmfc_edge)
			sync_n <= 1'b1;
	end
endmodule

// File: lkmon_top.sv
// lkmon_top.sv: link enable gate, link start sequence and alarm monitor
// Summary of operation
// - link enable low holds the serial block in reset, serializers down, clocks gated.
// - host sets link enable after configuring; device then releases and runs the link.
// - subclass 0 needs no timing reference; multiframe clock free-runs, phase unknown.
// - receiver sync request starts group sync and alignment in subclass 0 too.
// - five alarm flags: pll unlock, link down, realign, osc upset, clock upset.
// - alarm flags are sticky and clear only on a host write of one.
// - summary alarm asserts only for flags not suppressed by their mask bit.
// - calibration pin shows the summary alarm when selected as alarm output.
// - oscillator accumulators compared every cycle; any mismatch sets osc upset flag.
// - channel B may select a different oscillator than channel A by its pins.
// - oscillator comparison counts only after sync by reference or alignment start.
// - channel clocks compared; one device clock cycle of difference sets clock upset flag.
// - clock upset flag may be set after global power-down exit; host clears it.
// - dual-channel mode: each channel samples at device rate on its own input.
// - input swap bit exchanges the analog inputs feeding the two channels in dual mode only.
// - while sync request is held, device sends continuous comma characters.
// - after sync release, wait next multiframe edge, then four alignment multiframes.
module lkmon_top
	import lkmon_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESETN,
	// link control
	input wire logic LINK_ENABLE_BIT,
	input wire logic SYNC_N,
	input wire logic SUBCLASS1,
	input wire logic TIMING_REF,
	input wire logic SERDES_PLL_LOCKED,
	input wire logic DUAL_MODE,
	input wire logic INPUT_SWAP,
	// oscillator control
	input wire logic OSC_SYNC_SEL,
	input wire logic [1:0] OSC_SELECT_PINS_A,
	input wire logic [1:0] OSC_SELECT_PINS_B,
	input wire logic [OSC_ACC_W-1:0] FREQ_WORD_CHAN_A,
	input wire logic [OSC_ACC_W-1:0] FREQ_WORD_CHAN_B,
	input wire logic [OSC_ACC_W-1:0] PHASE_WORD_CHAN_A,
	input wire logic [OSC_ACC_W-1:0] PHASE_WORD_CHAN_B,
	input wire logic CLK_PHASE_CHAN_A,
	input wire logic CLK_PHASE_CHAN_B,
	// alarm host access
	input wire logic [4:0] ALARM_CLEAR_WR,
	input wire logic ALARM_CLEAR_STB,
	input wire logic [4:0] ALARM_MASK,
	input wire logic CAL_PIN_ALARM_SEL,
	input wire logic CAL_DONE,
	// outputs
	output logic SERIAL_RESET_N,
	output logic SERIALIZER_PWR_ON,
	output logic SERIAL_CLK_EN,
	output logic [7:0] TX_CHAR,
	output logic TX_IS_K,
	output logic ILAS_ACTIVE,
	output logic LMFC_EDGE,
	output logic [4:0] ALARM_FLAG_SET,
	output logic ALARM_SUMMARY,
	output logic CAL_ALARM_PIN,
	output logic CHAN_A_FROM_INPUT_B,
	output logic CHAN_B_FROM_INPUT_A,
	output logic [1:0] OSC_SEL_A,
	output logic [1:0] OSC_SEL_B
);
	lkmon_state_e state_ff, nxt_state;
	logic en_ff;
	logic [4:0] lmfc_cnt_ff;
	logic [2:0] mf_cnt_ff;
	logic [4:0] flags_ff;
	logic [OSC_ACC_W-1:0] acc_a_ff, acc_b_ff;
	logic osc_synced_ff;
	logic ref_d_ff;
	logic summary_ff, cal_ff, lmfc_edge_ff;
	logic [7:0] char_ff;
	logic k_ff, ilas_ff, swap_a_ff, swap_b_ff;
	logic [1:0] sel_a_ff, sel_b_ff;

	lkmon_upset_if up ();

	// ----------------------------------------
	// link enable gate
	// ----------------------------------------
	// one register stage so all three gate outputs move together
	always_ff @(posedge CLOCK)
	begin
		if (!RESETN)
			en_ff <= 1'b0;
		else
			en_ff <= LINK_ENABLE_BIT;
	end
	assign SERIAL_RESET_N = en_ff;
	assign SERIALIZER_PWR_ON = en_ff;
	assign SERIAL_CLK_EN = en_ff;

	// ----------------------------------------
	// local multiframe clock
	// ----------------------------------------
	// reference edge realigns in subclass 1; subclass 0 just free-runs
	wire ref_rise = TIMING_REF && !ref_d_ff;
	wire realign = SUBCLASS1 && ref_rise && en_ff && (lmfc_cnt_ff != 5'h00);
	wire lmfc_wrap = (lmfc_cnt_ff == LMFC_PERIOD_M1);
	always_ff @(posedge CLOCK)
	begin
		if (!RESETN || !en_ff)
			lmfc_cnt_ff <= 5'h00;
		else if (SUBCLASS1 && ref_rise)
			lmfc_cnt_ff <= 5'h00;
		else if (lmfc_wrap)
			lmfc_cnt_ff <= 5'h00;
		else
			lmfc_cnt_ff <= lmfc_cnt_ff + 5'h01;
	end
	always_ff @(posedge CLOCK)
	begin
		if (!RESETN)
		begin
			ref_d_ff <= 1'b0;
			lmfc_edge_ff <= 1'b0;
		end
		else
		begin
			ref_d_ff <= TIMING_REF;
			lmfc_edge_ff <= en_ff && lmfc_wrap;
		end
	end
	assign LMFC_EDGE = lmfc_edge_ff;

	// ----------------------------------------
	// link start sequence
	// ----------------------------------------
	// sync handling is identical in both subclasses
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			LK_OFF: if (en_ff) nxt_state = LK_CGS;
			LK_CGS: if (SYNC_N) nxt_state = LK_WAIT_LMFC;
			LK_WAIT_LMFC: if (!SYNC_N) nxt_state = LK_CGS;
				else if (lmfc_wrap) nxt_state = LK_ILAS;
			LK_ILAS: if (!SYNC_N) nxt_state = LK_CGS;
				else if (lmfc_wrap && mf_cnt_ff == ILAS_MULTIFRAMES - 3'h1)
					nxt_state = LK_DATA;
			LK_DATA: if (!SYNC_N) nxt_state = LK_CGS;
			default: nxt_state = LK_OFF;
		endcase
		if (!en_ff)
			nxt_state = LK_OFF;
	end
	always_ff @(posedge CLOCK)
	begin
		if (!RESETN)
			state_ff <= LK_OFF;
		else
			state_ff <= nxt_state;
	end
	// multiframes sent so far in the alignment sequence
	always_ff @(posedge CLOCK)
	begin
		if (!RESETN || state_ff != LK_ILAS)
			mf_cnt_ff <= 3'h0;
		else if (lmfc_wrap)
			mf_cnt_ff <= mf_cnt_ff + 3'h1;
	end
	// character stream: commas during group sync and the multiframe wait, otherwise 8'h00 with the K flag low
	wire send_comma = (nxt_state == LK_CGS) || (nxt_state == LK_WAIT_LMFC);
	always_ff @(posedge CLOCK)
	begin
		if (!RESETN)
		begin
			char_ff <= 8'h00;
			k_ff <= 1'b0;
			ilas_ff <= 1'b0;
		end
		else
		begin
			char_ff <= send_comma ? K28_5_CHAR : 8'h00;
			k_ff <= send_comma;
			ilas_ff <= (nxt_state == LK_ILAS);
		end
	end
	assign TX_CHAR = char_ff;
	assign TX_IS_K = k_ff;
	assign ILAS_ACTIVE = ilas_ff;

	// ----------------------------------------
	// channel routing and oscillators
	// ----------------------------------------
	// swap only meaningful in dual mode; single mode forces both swap outputs low
	always_ff @(posedge CLOCK)
	begin
		if (!RESETN)
		begin
			swap_a_ff <= 1'b0;
			swap_b_ff <= 1'b0;
			sel_a_ff <= 2'h0;
			sel_b_ff <= 2'h0;
		end
		else
		begin
			swap_a_ff <= DUAL_MODE && INPUT_SWAP;
			swap_b_ff <= DUAL_MODE && INPUT_SWAP;
			sel_a_ff <= OSC_SELECT_PINS_A;
			sel_b_ff <= OSC_SELECT_PINS_B;
		end
	end
	assign CHAN_A_FROM_INPUT_B = swap_a_ff;
	assign CHAN_B_FROM_INPUT_A = swap_b_ff;
	assign OSC_SEL_A = sel_a_ff;
	assign OSC_SEL_B = sel_b_ff;

	// sync trigger chosen by setting: reference edge or alignment start
	wire ilas_start = (state_ff == LK_WAIT_LMFC) && (nxt_state == LK_ILAS);
	wire osc_sync = (OSC_SYNC_SEL == OSC_SYNC_BY_ILAS) ? ilas_start : ref_rise;
	// accumulators load phase on sync; index choice is upstream of the word ports
	always_ff @(posedge CLOCK)
	begin
		if (!RESETN || !en_ff)
		begin
			acc_a_ff <= '0;
			acc_b_ff <= '0;
			osc_synced_ff <= 1'b0;
		end
		else if (osc_sync)
		begin
			acc_a_ff <= PHASE_WORD_CHAN_A;
			acc_b_ff <= PHASE_WORD_CHAN_B;
			osc_synced_ff <= 1'b1;
		end
		else
		begin
			acc_a_ff <= acc_a_ff + FREQ_WORD_CHAN_A;
			acc_b_ff <= acc_b_ff + FREQ_WORD_CHAN_B;
		end
	end
	assign up.acc_a = acc_a_ff;
	assign up.acc_b = acc_b_ff;
	assign up.osc_valid = osc_synced_ff;
	assign up.clk_phase_a = CLK_PHASE_CHAN_A;
	assign up.clk_phase_b = CLK_PHASE_CHAN_B;

	lkmon_upset_det lkmon_upset_det_i (
		.clk(CLOCK),
		.rst_n(RESETN),
		.up(up)
	);

	// ----------------------------------------
	// alarm flags
	// ----------------------------------------
	wire [4:0] alarm_cause = {up.clk_mismatch, up.osc_mismatch, realign,
		en_ff && state_ff != LK_DATA, en_ff && !SERDES_PLL_LOCKED};
	wire [4:0] clear_req = ALARM_CLEAR_STB ? ALARM_CLEAR_WR : 5'h00;
	// a cause in the clearing cycle wins so no event is lost
	wire [4:0] nxt_flags = (flags_ff & ~clear_req) | alarm_cause;
	wire nxt_summary = |(nxt_flags & ~ALARM_MASK);
	always_ff @(posedge CLOCK)
	begin
		if (!RESETN)
		begin
			flags_ff <= ALARM_FLAGS_RESET;
			summary_ff <= 1'b0;
			cal_ff <= 1'b0;
		end
		else
		begin
			flags_ff <= nxt_flags;
			summary_ff <= nxt_summary;
			cal_ff <= CAL_PIN_ALARM_SEL ? nxt_summary : CAL_DONE;
		end
	end
	assign ALARM_FLAG_SET = flags_ff;
	assign ALARM_SUMMARY = summary_ff;
	assign CAL_ALARM_PIN = cal_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_gate;
		@(posedge CLOCK) disable iff (!RESETN)
		!LINK_ENABLE_BIT |=> !SERIAL_RESET_N && !SERIALIZER_PWR_ON && !SERIAL_CLK_EN;
	endproperty
	a_gate: assert property (p_gate) else $error("link block not held off");
	property p_release;
		@(posedge CLOCK) disable iff (!RESETN)
		LINK_ENABLE_BIT [*2] |-> SERIAL_RESET_N;
	endproperty
	a_release: assert property (p_release) else $error("link block not released");
	property p_sticky;
		@(posedge CLOCK) disable iff (!RESETN)
		(flags_ff[ALM_OSC_UPSET] && !(ALARM_CLEAR_STB && ALARM_CLEAR_WR[ALM_OSC_UPSET]))
			|=> flags_ff[ALM_OSC_UPSET];
	endproperty
	a_sticky: assert property (p_sticky) else $error("alarm flag dropped");
	property p_summary;
		@(posedge CLOCK) disable iff (!RESETN)
		ALARM_SUMMARY == |(ALARM_FLAG_SET & ~$past(ALARM_MASK));
	endproperty
	a_summary: assert property (p_summary) else $error("summary alarm wrong");
	property p_cal;
		@(posedge CLOCK) disable iff (!RESETN)
		(CAL_PIN_ALARM_SEL && nxt_summary) |=> CAL_ALARM_PIN;
	endproperty
	a_cal: assert property (p_cal) else $error("cal pin missed alarm");
	property p_clk_upset;
		@(posedge CLOCK) disable iff (!RESETN)
		(CLK_PHASE_CHAN_A != CLK_PHASE_CHAN_B) |-> ##2 flags_ff[ALM_CLK_UPSET];
	endproperty
	a_clk_upset: assert property (p_clk_upset) else $error("clock upset missed");
	property p_comma;
		@(posedge CLOCK) disable iff (!RESETN)
		(state_ff == LK_CGS && !SYNC_N && en_ff) |=> TX_IS_K && TX_CHAR == K28_5_CHAR;
	endproperty
	a_comma: assert property (p_comma) else $error("no comma during sync");
	property p_wait_edge;
		@(posedge CLOCK) disable iff (!RESETN)
		$rose(ILAS_ACTIVE) |-> LMFC_EDGE;
	endproperty
	a_wait_edge: assert property (p_wait_edge) else $error("alignment off edge");
	property p_zero_wr;
		@(posedge CLOCK) disable iff (!RESETN)
		(ALARM_CLEAR_STB && ALARM_CLEAR_WR == 5'h00) |=> (flags_ff & $past(flags_ff)) == $past(flags_ff);
	endproperty
	a_zero_wr: assert property (p_zero_wr) else $error("zero write cleared flag");
endmodule

// File: lkmon_upset_det.sv
// lkmon_upset_det.sv: channel A against channel B upset comparators
module lkmon_upset_det
	import lkmon_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// comparison signals
	lkmon_upset_if.detector up
);
	logic osc_mm_ff;
	logic clk_mm_ff;
	wire osc_diff = up.acc_a != up.acc_b;
	wire clk_diff = up.clk_phase_a != up.clk_phase_b;
	// registered compare; one differing cycle is enough to report
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			osc_mm_ff <= 1'b0;
			clk_mm_ff <= 1'b0;
		end
		else
		begin
			osc_mm_ff <= up.osc_valid && osc_diff;
			clk_mm_ff <= clk_diff;
		end
	end
	assign up.osc_mismatch = osc_mm_ff;
	assign up.clk_mismatch = clk_mm_ff;
	property p_osc_cmp;
		@(posedge clk) disable iff (!rst_n)
		(up.osc_valid && osc_diff) |=> up.osc_mismatch;
	endproperty
	a_osc_cmp: assert property (p_osc_cmp) else $error("osc mismatch not reported");
	property p_osc_gate;
		@(posedge clk) disable iff (!rst_n)
		!up.osc_valid |=> !up.osc_mismatch;
	endproperty
	a_osc_gate: assert property (p_osc_gate) else $error("osc compare before sync");
endmodule

// File: lkmon_upset_if.sv
// lkmon_upset_if.sv: channel comparison signals between monitor and detector
interface lkmon_upset_if;
	import lkmon_pkg::*;
	logic [OSC_ACC_W-1:0] acc_a;
	logic [OSC_ACC_W-1:0] acc_b;
	logic clk_phase_a;
	logic clk_phase_b;
	logic osc_valid;
	logic osc_mismatch;
	logic clk_mismatch;
	modport monitor (output acc_a, acc_b, clk_phase_a, clk_phase_b, osc_valid,
		input osc_mismatch, clk_mismatch);
	modport detector (input acc_a, acc_b, clk_phase_a, clk_phase_b, osc_valid,
		output osc_mismatch, clk_mismatch);
endinterface
